// *** verilog/pol_protection_status_logic.sv ***
// Pre-bias hold-off, power-good window and fault shutdown of the converter
// How it works
// - Power stage stays off until the rising reference passes the output.
// - Limit code bits 3:0 pick overcurrent threshold percent; 0xB default.
// - Limit codes above 0xB act as 0xB, the 140 percent threshold.
// - Temperature warning sets above 120 C and clears below 117 C.
// - Warnings only change status and the pin, never turn off.
// - Pin pulled low outside window: high 105/110, low 90/95 percent.
// - Window checking starts only once the ramp reaches steady state.
// - Pin release waits a programmed 0 to 150 ms after steady state.
// - Window stays checked while margining, limits follow moving setpoint.
// - Warning pulls pin low, status 0; back in window releases both.
// - An external low on the pin is sensed as a power-good warning.
// - Option: pin drops at the off command or at ramp-down start.
// - Overcurrent, overtemperature, undervoltage or tracking faults turn off.
// - Overcurrent armed above pre-bias; trip clears bit, both switches off.
// - Limit register bit enables temperature compensation, default on.
// - Undervoltage armed in steady state; without overcurrent, ramped off.
// - Overtemperature always armed; above 130 C clears bit, ramped off.
// - Non-latching overtemperature restarts once below 117 C.
// - Rising ramp, if enabled: error above 250 mV trips, both off.
// - Window and undervoltage thresholds are percentages of the present setpoint.
// - Tracking stops at power good; margining does not re-arm it.
`timescale 1ns/1ps
`default_nettype none

module pol_protection_status_logic #(
    parameter int MS_CYCLES = pol_protection_pkg::MS_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic turn_on,
    input wire logic [11:0] vout_meas,
    input wire logic [11:0] vout_setpoint,
    input wire logic [11:0] ramp_ref,
    input wire logic ramp_at_target,
    input wire logic ramp_down_active,
    input wire logic off_done,
    input wire logic [7:0] load_current_pct,
    input wire logic [7:0] temp_c,
    input wire logic cls_wr,
    input wire logic [7:0] cls_wdata,
    output logic [7:0] current_limit_setpoint,
    input wire logic [7:0] protection_config_one,
    input wire logic [7:0] protection_config_thresholds,
    input wire logic [7:0] pg_delay_ms,
    input wire logic pg_pin_in,
    output logic pg_pin_out,
    output logic pg_pin_oe,
    output logic stage_enable,
    output logic soft_off,
    output logic fast_off,
    output logic [7:0] protection_status
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [19:0] scaled(input logic [11:0] v,
                                           input logic [7:0] pct);
        return 20'(v) * 20'(pct);
    endfunction : scaled

    pol_protection_pkg::conv_state_e state;
    pol_protection_pkg::conv_state_e next_state;
    logic [11:0] prebias;
    logic hold_off;
    logic only_ot;
    logic track_armed;
    logic [2:0] pg_sync;
    logic pg_sensed;
    logic [15:0] ms_cnt;
    logic [7:0] ms_elapsed;
    logic delay_done;
    logic temp_warn;
    logic pg_released;
    logic next_release;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            current_limit_setpoint <= pol_protection_pkg::CLS_RESET;
        end else if (cls_wr) begin
            current_limit_setpoint <= cls_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Thresholds

    logic [3:0] limit_code;
    logic [8:0] oc_threshold;
    logic [7:0] temp_over;
    logic [7:0] pg_hi_pct;
    logic [7:0] pg_lo_pct;
    logic [7:0] uv_pct;
    logic [19:0] vout_x100;
    logic window_ok;
    logic [11:0] track_err;

    always_comb begin
        limit_code = current_limit_setpoint[pol_protection_pkg::CLS_LIMIT_MSB:0];
        if (limit_code > pol_protection_pkg::CLS_LIMIT_MAX) begin
            limit_code = pol_protection_pkg::CLS_LIMIT_MAX;
        end
    end

    // Choke copper drifts upward with heat, so the trip point is raised
    assign temp_over = (temp_c > pol_protection_pkg::TEMP_COMP_BASE) ?
        8'(temp_c - pol_protection_pkg::TEMP_COMP_BASE) : 8'h00;
    assign oc_threshold = 9'(pol_protection_pkg::limit_pct(limit_code)) +
        ((current_limit_setpoint[pol_protection_pkg::CLS_TEMPCOMP_BIT]) ?
        9'(temp_over >> pol_protection_pkg::TEMP_COMP_SHIFT) : 9'h000);

    assign pg_hi_pct =
        protection_config_thresholds[pol_protection_pkg::PC2_PG_HI_BIT] ?
        pol_protection_pkg::PG_HI_HIGH : pol_protection_pkg::PG_HI_LOW;
    assign pg_lo_pct =
        protection_config_thresholds[pol_protection_pkg::PC2_PG_LO_BIT] ?
        pol_protection_pkg::PG_LO_HIGH : pol_protection_pkg::PG_LO_LOW;
    assign uv_pct = pol_protection_pkg::UV_PCT_BASE +
        8'(protection_config_thresholds[pol_protection_pkg::PC2_UV_LSB +: 2]
        * pol_protection_pkg::UV_PCT_STEP);

    // Percent limits follow the live setpoint through margining moves
    assign vout_x100 = scaled(vout_meas, pol_protection_pkg::PCT_UNITY);
    assign window_ok = (vout_x100 <= scaled(vout_setpoint, pg_hi_pct)) &&
        (vout_x100 >= scaled(vout_setpoint, pg_lo_pct));
    assign track_err = (vout_meas > ramp_ref) ?
        (vout_meas - ramp_ref) : (ramp_ref - vout_meas);

    ////////////////////////////////////////////////////////////////////////////
    // Fault detection

    logic powered;
    logic oc_hit;
    logic uv_hit;
    logic ot_hit;
    logic trk_hit;

    assign powered = (state == pol_protection_pkg::ST_RAMP) ||
        (state == pol_protection_pkg::ST_STEADY) ||
        (state == pol_protection_pkg::ST_SOFT_OFF);
    assign oc_hit = powered && (vout_meas > prebias) &&
        (9'(load_current_pct) >= oc_threshold);
    assign uv_hit = (state == pol_protection_pkg::ST_STEADY) && !oc_hit &&
        (vout_x100 < scaled(vout_setpoint, uv_pct));
    assign ot_hit = temp_c > pol_protection_pkg::TEMP_OT_TRIP;
    assign trk_hit = (state == pol_protection_pkg::ST_RAMP) && track_armed &&
        protection_config_one[pol_protection_pkg::PC1_TRACK_EN_BIT] &&
        (track_err > pol_protection_pkg::TRACK_LIMIT_LSB);

    ////////////////////////////////////////////////////////////////////////////
    // Converter sequencing

    always_comb begin
        next_state = state;
        unique case (state)
            pol_protection_pkg::ST_IDLE: begin
                if (turn_on && !hold_off && !ot_hit) begin
                    next_state = pol_protection_pkg::ST_HOLD;
                end
            end
            pol_protection_pkg::ST_HOLD: begin
                if (!turn_on || ot_hit) begin
                    next_state = pol_protection_pkg::ST_IDLE;
                end else if (ramp_ref > vout_meas) begin
                    next_state = pol_protection_pkg::ST_RAMP;
                end
            end
            pol_protection_pkg::ST_RAMP: begin
                if (oc_hit || trk_hit) begin
                    next_state = pol_protection_pkg::ST_FAST_OFF;
                end else if (ot_hit || !turn_on) begin
                    next_state = pol_protection_pkg::ST_SOFT_OFF;
                end else if (ramp_at_target) begin
                    next_state = pol_protection_pkg::ST_STEADY;
                end
            end
            pol_protection_pkg::ST_STEADY: begin
                if (oc_hit) begin
                    next_state = pol_protection_pkg::ST_FAST_OFF;
                end else if (ot_hit || uv_hit || !turn_on) begin
                    next_state = pol_protection_pkg::ST_SOFT_OFF;
                end
            end
            pol_protection_pkg::ST_SOFT_OFF: begin
                if (oc_hit) begin
                    next_state = pol_protection_pkg::ST_FAST_OFF;
                end else if (off_done) begin
                    next_state = pol_protection_pkg::ST_IDLE;
                end
            end
            pol_protection_pkg::ST_FAST_OFF: begin
                next_state = pol_protection_pkg::ST_IDLE;
            end
            default: begin
                next_state = pol_protection_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= pol_protection_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Output level at start is taken as the pre-bias
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prebias <= 12'h000;
        end else if (state == pol_protection_pkg::ST_IDLE) begin
            prebias <= vout_meas;
        end
    end

    // A fault other than a lone non-latching overtemperature keeps the converter off until the on command is dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hold_off <= 1'b0;
            only_ot <= 1'b0;
        end else if (oc_hit || uv_hit || trk_hit) begin
            hold_off <= 1'b1;
            only_ot <= 1'b0;
        end else if (ot_hit) begin
            if (!hold_off) begin
                only_ot <= 1'b1;
            end
            hold_off <= 1'b1;
        end else if (!turn_on) begin
            hold_off <= 1'b0;
            only_ot <= 1'b0;
        end else if (only_ot && !temp_warn &&
                     protection_config_one[pol_protection_pkg::PC1_OT_NONLATCH_BIT]) begin
            hold_off <= 1'b0;
            only_ot <= 1'b0;
        end
    end

    // Ramp tracking ends until the next start once power good is first reported
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            track_armed <= 1'b0;
        end else if (state == pol_protection_pkg::ST_HOLD) begin
            track_armed <= 1'b1;
        end else if (pg_released) begin
            track_armed <= 1'b0;
        end
    end

    assign stage_enable = powered;
    assign soft_off = (state == pol_protection_pkg::ST_SOFT_OFF);
    assign fast_off = (state == pol_protection_pkg::ST_FAST_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Power-good pin

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pg_sync <= 3'h7;
            pg_sensed <= 1'b1;
        end else begin
            pg_sync <= {pg_sync[1:0], pg_pin_in};
            if (pg_sync[1] == pg_sync[2]) begin
                pg_sensed <= pg_sync[2];
            end
        end
    end

    // Release delay counted in milliseconds from steady state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ms_cnt <= 16'h0000;
            ms_elapsed <= 8'h00;
        end else if (state != pol_protection_pkg::ST_STEADY) begin
            ms_cnt <= 16'h0000;
            ms_elapsed <= 8'h00;
        end else if (!delay_done) begin
            if (ms_cnt == 16'(MS_CYCLES - 1)) begin
                ms_cnt <= 16'h0000;
                ms_elapsed <= ms_elapsed + 8'h01;
            end else begin
                ms_cnt <= ms_cnt + 16'h0001;
            end
        end
    end

    assign delay_done = (ms_elapsed >= pg_delay_ms) ||
        (ms_elapsed >= pol_protection_pkg::PG_DELAY_MAX_MS);

    always_comb begin
        next_release = 1'b0;
        if (state == pol_protection_pkg::ST_STEADY) begin
            next_release = delay_done && window_ok;
            if (!turn_on && !protection_config_thresholds
                    [pol_protection_pkg::PC2_PG_MODE_BIT]) begin
                next_release = 1'b0;
            end
        end else if (state == pol_protection_pkg::ST_SOFT_OFF) begin
            // An off command or an overtemperature may keep the pin up until ramp-down
            next_release = pg_released && !ramp_down_active && !uv_hit &&
                protection_config_thresholds[pol_protection_pkg::PC2_PG_MODE_BIT];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pg_released <= 1'b0;
        end else begin
            pg_released <= next_release;
        end
    end

    assign pg_pin_out = 1'b0;
    assign pg_pin_oe = !pg_released;

    ////////////////////////////////////////////////////////////////////////////
    // Status

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            temp_warn <= 1'b0;
        end else if (temp_c > pol_protection_pkg::TEMP_WARN_SET) begin
            temp_warn <= 1'b1;
        end else if (temp_c < pol_protection_pkg::TEMP_WARN_CLR) begin
            temp_warn <= 1'b0;
        end
    end

    // Fault bits rearm at each fresh start; a trip in that cycle still wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            protection_status <= pol_protection_pkg::ST_RESET;
        end else begin
            if (next_state == pol_protection_pkg::ST_HOLD &&
                state == pol_protection_pkg::ST_IDLE) begin
                protection_status[pol_protection_pkg::ST_OVERCURRENT] <= 1'b1;
                protection_status[pol_protection_pkg::ST_UNDERVOLTAGE] <= 1'b1;
                protection_status[pol_protection_pkg::ST_OVERTEMP] <= 1'b1;
                protection_status[pol_protection_pkg::ST_TRACKING] <= 1'b1;
            end
            protection_status[pol_protection_pkg::ST_TEMP_WARN] <= !temp_warn;
            protection_status[pol_protection_pkg::ST_POWER_GOOD] <=
                pg_released && pg_sensed;
            if (oc_hit) begin
                protection_status[pol_protection_pkg::ST_OVERCURRENT] <= 1'b0;
            end
            if (uv_hit) begin
                protection_status[pol_protection_pkg::ST_UNDERVOLTAGE] <= 1'b0;
            end
            if (ot_hit) begin
                protection_status[pol_protection_pkg::ST_OVERTEMP] <= 1'b0;
            end
            if (trk_hit) begin
                protection_status[pol_protection_pkg::ST_TRACKING] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_oc_trip;
        oc_hit ##1 fast_off;
    endsequence

    sequence s_uv_trip;
        uv_hit ##1 (soft_off && !fast_off);
    endsequence

    a_prebias_hold: assert property (
        (state == pol_protection_pkg::ST_HOLD && ramp_ref <= vout_meas)
        |=> !stage_enable)
        else $error("power stage started below pre-bias");

    a_limit_clamp: assert property (
        (current_limit_setpoint[3:0] > 4'hB &&
         !current_limit_setpoint[pol_protection_pkg::CLS_TEMPCOMP_BIT])
        |-> oc_threshold == 9'h08C)
        else $error("limit code above 0xB not clamped");

    a_temp_warn_hyst: assert property (
        (temp_c > 8'h78) ##1 (temp_c >= 8'h75) [*2]
        |=> !protection_status[pol_protection_pkg::ST_TEMP_WARN])
        else $error("temperature warning lost inside hysteresis");

    a_warning_no_off: assert property (
        (state == pol_protection_pkg::ST_STEADY && turn_on &&
         !oc_hit && !uv_hit && !ot_hit)
        |=> state == pol_protection_pkg::ST_STEADY)
        else $error("warning turned the converter off");

    a_pg_out_window: assert property (
        (state == pol_protection_pkg::ST_STEADY && !window_ok) |=> pg_pin_oe)
        else $error("power good released outside window");

    a_pg_not_early: assert property (
        (state != pol_protection_pkg::ST_STEADY &&
         state != pol_protection_pkg::ST_SOFT_OFF) |=> pg_pin_oe)
        else $error("power good released before steady state");

    a_oc_fast_off: assert property (
        oc_hit |-> s_oc_trip)
        else $error("overcurrent did not force fast turn-off");

    a_oc_status: assert property (
        oc_hit |=> !protection_status[pol_protection_pkg::ST_OVERCURRENT])
        else $error("overcurrent bit not cleared");

    a_uv_ramped_off: assert property (
        uv_hit |-> s_uv_trip)
        else $error("undervoltage did not start ramped turn-off");

    a_track_fast_off: assert property (
        trk_hit |=> fast_off &&
            !protection_status[pol_protection_pkg::ST_TRACKING])
        else $error("tracking error did not trip");

    a_ot_ramped_off: assert property (
        (ot_hit && state == pol_protection_pkg::ST_STEADY && !oc_hit)
        |=> soft_off ##1 !$rose(stage_enable))
        else $error("overtemperature did not ramp off");

endmodule : pol_protection_status_logic

`default_nettype wire

// *** shared/pol_protection_pkg.sv ***
// Constants, field layout and lookups for the converter protection logic
package pol_protection_pkg;

    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96;

    // Output voltage words: 12 bits, 2.5 mV per step
    localparam int LSB_UV = 2500;
    localparam int TRACK_LIMIT_MV = 250;
    localparam logic [11:0] TRACK_LIMIT_LSB =
        12'((TRACK_LIMIT_MV * 1000) / LSB_UV);

    // Temperatures in whole degrees C
    localparam logic [7:0] TEMP_WARN_SET = 8'h78;
    localparam logic [7:0] TEMP_WARN_CLR = 8'h75;
    localparam logic [7:0] TEMP_OT_TRIP = 8'h82;
    localparam logic [7:0] TEMP_COMP_BASE = 8'h19;
    localparam int TEMP_COMP_SHIFT = 3;

    // current_limit_setpoint layout
    localparam int CLS_LIMIT_MSB = 3;
    localparam int CLS_TEMPCOMP_BIT = 4;
    localparam logic [3:0] CLS_LIMIT_MAX = 4'hB;
    localparam logic [7:0] CLS_RESET = 8'h1B;

    // protection_config_one layout
    localparam int PC1_TRACK_EN_BIT = 0;
    localparam int PC1_OT_NONLATCH_BIT = 1;

    // protection_config_thresholds layout
    localparam int PC2_PG_HI_BIT = 0;
    localparam int PC2_PG_LO_BIT = 1;
    localparam int PC2_UV_LSB = 2;
    localparam int PC2_PG_MODE_BIT = 4;

    // Window percentages
    localparam logic [7:0] PCT_UNITY = 8'h64;
    localparam logic [7:0] PG_HI_LOW = 8'h69;
    localparam logic [7:0] PG_HI_HIGH = 8'h6E;
    localparam logic [7:0] PG_LO_LOW = 8'h5A;
    localparam logic [7:0] PG_LO_HIGH = 8'h5F;
    localparam logic [7:0] UV_PCT_BASE = 8'h4B;
    localparam logic [7:0] UV_PCT_STEP = 8'h05;

    // protection_status bits, active low except power good, which reads 1 when good
    localparam int ST_TEMP_WARN = 0;
    localparam int ST_POWER_GOOD = 1;
    localparam int ST_OVERCURRENT = 2;
    localparam int ST_UNDERVOLTAGE = 3;
    localparam int ST_OVERTEMP = 4;
    localparam int ST_TRACKING = 5;
    localparam logic [7:0] ST_RESET = 8'h3F;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HOLD = 6'b000010,
        ST_RAMP = 6'b000100,
        ST_STEADY = 6'b001000,
        ST_SOFT_OFF = 6'b010000,
        ST_FAST_OFF = 6'b100000
    } conv_state_e;

    // Overcurrent threshold in percent of rated current
    function automatic logic [7:0] limit_pct(input logic [3:0] code);
        logic [7:0] pct;
        pct = 8'h8C;
        case (code)
            4'h0: pct = 8'h25;
            4'h1: pct = 8'h2F;
            4'h2: pct = 8'h39;
            4'h3: pct = 8'h42;
            4'h4: pct = 8'h4C;
            4'h5: pct = 8'h55;
            4'h6: pct = 8'h5E;
            4'h7: pct = 8'h67;
            4'h8: pct = 8'h70;
            4'h9: pct = 8'h79;
            4'hA: pct = 8'h83;
            default: pct = 8'h8C;
        endcase
        return pct;
    endfunction : limit_pct

endpackage : pol_protection_pkg

// *** verification/power_manager_model.sv ***
// Power manager stand-in: configuration, limit writes, pin pull-down
`timescale 1ns/1ps
`default_nettype none
module power_manager_model (
    input wire logic clock,
    output logic cls_wr,
    output logic [7:0] cls_wdata,
    output logic [7:0] config_one,
    output logic [7:0] config_thr,
    output logic [7:0] delay_ms,
    output logic ext_pull
);
    initial begin
        {cls_wr, cls_wdata, config_one, config_thr, ext_pull} = '0;
        delay_ms = 8'h02;
    end
    // One-cycle strobe, launched away from the sampling edge
    task automatic write_cls(input logic [7:0] d);
        @(negedge clock);
        cls_wr = 1'b1;
        cls_wdata = d;
        @(negedge clock);
        cls_wr = 1'b0;
    endtask : write_cls
endmodule : power_manager_model
`default_nettype wire

// *** verification/tb_pol_protection_status_logic.sv ***
// Self-checking bench for the converter protection and status logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
$display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb_pol_protection_status_logic;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic turn_on, at_tgt, ramp_down_active, off_done, ext_pull, cls_wr;
    logic [11:0] vout_meas, vout_setpoint, ramp_ref;
    logic [7:0] load_current_pct, temp_c, cls_wdata, cfg1, cfg2, dly;
    logic [7:0] current_limit_setpoint, protection_status;
    logic pg_pin_out, pg_pin_oe, stage_enable, soft_off, fast_off;
    int error_cnt = 0;
    int n_checks = 0;
    int sp, hi, lo;
    // Weak pull-up unless either party pulls the wire low
    wire logic pg_wire = ~(pg_pin_oe | ext_pull);
    always #25 clock = ~clock;
    pol_protection_status_logic #(.MS_CYCLES(4))
    pol_protection_status_logic_inst (.clock, .arst_n, .turn_on, .vout_meas,
        .vout_setpoint, .ramp_ref, .ramp_at_target(at_tgt), .ramp_down_active,
        .off_done, .load_current_pct, .temp_c, .cls_wr, .cls_wdata,
        .current_limit_setpoint, .protection_config_one(cfg1),
        .protection_config_thresholds(cfg2), .pg_delay_ms(dly),
        .pg_pin_in(pg_wire), .pg_pin_out, .pg_pin_oe, .stage_enable,
        .soft_off, .fast_off, .protection_status);
    power_manager_model power_manager_model_inst (.clock, .cls_wr, .cls_wdata,
        .config_one(cfg1), .config_thr(cfg2), .delay_ms(dly), .ext_pull);
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic seen(ref logic s, input logic v);
        for (int k = 0; k < 12 && s !== v; k++) @(negedge clock);
        `CHK(s, v)
    endtask : seen
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic bring_up(input int pre);
        arst_n = 1'b0;
        {turn_on, at_tgt, ramp_down_active, load_current_pct} = '0;
        temp_c = 8'h19;
        vout_setpoint = 12'(sp);
        vout_meas = 12'(pre);
        ramp_ref = 12'(pre);
        cyc(2);
        arst_n = 1'b1;
        turn_on = 1'b1;
        cyc(4);
        `CHK(stage_enable, 1'b0)
        ramp_ref = 12'(pre + 1);
        cyc(2);
        `CHK(stage_enable, 1'b1)
        ramp_ref = 12'(sp);
        cyc(1);
        vout_meas = 12'(sp);
        at_tgt = 1'b1;
        cyc(2);
    endtask : bring_up
    // Whole run is under 3000 cycles
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        {turn_on, at_tgt, ramp_down_active, off_done, vout_meas,
            vout_setpoint, ramp_ref, load_current_pct, temp_c} = '0;
        void'($urandom(32'h6D370A5C));
        cyc(5);
        `CHK(current_limit_setpoint, 8'h1B)
        `CHK(protection_status, 8'h3F)
        `CHK(pg_pin_oe, 1'b1)
        arst_n = 1'b1;
        repeat (4) begin
            sp = $urandom;
            power_manager_model_inst.write_cls(8'(sp));
            `CHK(current_limit_setpoint, 8'(sp))
        end
        // Code above the table with compensation off: plain 140 percent
        power_manager_model_inst.write_cls(8'h0F);
        `CHK(current_limit_setpoint, 8'h0F)
        $display("test limit register done");
        for (int m = 0; m < 2; m++) begin
            sp = 800 + $urandom % 2000;
            hi = sp * (105 + 5 * m) / 100;
            lo = sp * (90 + 5 * m) / 100;
            power_manager_model_inst.config_thr = 8'(m * 8'h13);
            bring_up(sp / 2);
            `CHK(pg_pin_oe, 1'b1)
            `CHK(protection_status[5], 1'b1)
            seen(pg_pin_oe, 1'b0);
            vout_meas = 12'(hi + 1);
            seen(pg_pin_oe, 1'b1);
            cyc(1);
            `CHK(protection_status[1], 1'b0)
            vout_meas = 12'(sp);
            seen(pg_pin_oe, 1'b0);
            cyc(5);
            `CHK(protection_status[1], 1'b1)
            vout_meas = 12'(lo - 1);
            seen(pg_pin_oe, 1'b1);
            `CHK(stage_enable, 1'b1)
            vout_meas = 12'(sp);
            seen(pg_pin_oe, 1'b0);
            vout_setpoint = 12'(sp * 6 / 5);
            seen(pg_pin_oe, 1'b1);
            vout_setpoint = 12'(sp);
            seen(pg_pin_oe, 1'b0);
            temp_c = 8'h79;
            cyc(2);
            `CHK(protection_status[0], 1'b0)
            temp_c = 8'h76;
            cyc(3);
            `CHK(protection_status[0], 1'b0)
            temp_c = 8'h74;
            cyc(2);
            `CHK(protection_status[0], 1'b1)
            power_manager_model_inst.ext_pull = 1'b1;
            cyc(6);
            `CHK(protection_status[1], 1'b0)
            `CHK(stage_enable, 1'b1)
            power_manager_model_inst.ext_pull = 1'b0;
            cyc(6);
            `CHK(protection_status[1], 1'b1)
            turn_on = 1'b0;
            if (m == 1) begin
                cyc(3);
                `CHK(pg_pin_oe, 1'b0)
                ramp_down_active = 1'b1;
            end
            seen(pg_pin_oe, 1'b1);
            $display("test window pass %0d done", m);
        end
        for (int f = 0; f < 4; f++) begin
            sp = 1000;
            power_manager_model_inst.config_one = 8'(f == 3);
            bring_up(0);
            case (f)
                0: load_current_pct = 8'h8B;
                1: vout_meas = 12'(sp * 3 / 4 - 1);
                2: temp_c = 8'h83;
                default: ;
            endcase
            if (f == 0) begin
                cyc(3);
                `CHK(stage_enable, 1'b1)
                load_current_pct = 8'h8C;
                seen(fast_off, 1'b1);
            end
            cyc(4);
            `CHK(protection_status[f + 2], 1'b0)
            if (f == 0 || f == 3) `CHK(stage_enable, 1'b0)
            else `CHK(soft_off, 1'b1)
            // Finish the ramped off, then only an overtemperature trip rearms
            if (f == 1 || f == 2) begin
                off_done = 1'b1;
                cyc(2);
                `CHK(soft_off, 1'b0)
                off_done = 1'b0;
                power_manager_model_inst.config_one = 8'h02;
                temp_c = 8'h74;
                cyc(4);
                `CHK(protection_status[f + 2], 1'(f == 2))
            end
            $display("test fault %0d done", f);
        end
        stop_test();
    end
endmodule : tb_pol_protection_status_logic
`default_nettype wire
